/* File: shared/masl_consts.svh */
// Constants for the monitor alert select logic: register index, bit
// positions, reset value. Assumes inclusion by bare name.
// Operation
// - Control register selects alert source and behaviour
// - Highest enabled limit bit alone uses limit
// - Over-limit asserts alert when result exceeds limit
// - Under-limit asserts alert when result below limit
// - Control register at index 06h, resets zero
// - Ready alert adds to limit; flag shows cause
// - Done flag set on completion, cleared by write/read
// - Latch clears on read; transparent on clean conversion
// - Alert active-low unless sense invert set
`ifndef MASL_CONSTS_SVH
`define MASL_CONSTS_SVH
`define MASL_CTRL_INDEX    8'h06
`define MASL_CTRL_RESET    16'h0000
`define MASL_WR_MASK       16'hFC03
`define MASL_REG_W         16
`define MASL_BIT_SH_OVER   15
`define MASL_BIT_SH_UNDER  14
`define MASL_BIT_BUS_OVER  13
`define MASL_BIT_BUS_UNDER 12
`define MASL_BIT_PWR_OVER  11
`define MASL_BIT_RDY       10
`define MASL_BIT_LIM_FLAG  4
`define MASL_BIT_DONE_FLAG 3
`define MASL_BIT_MATH_FLAG 2
`define MASL_BIT_INV       1
`define MASL_BIT_LATCH     0
`define MASL_EN_HI         15
`define MASL_EN_LO         10
`define MASL_FUNC_NONE     5'h00
`define MASL_FLAG_RESET    1'h0
`define MASL_OE_RELEASE    1'h1
`define MASL_PIN_LOW       1'h0
`endif

/* File: shared/masl_pkg.sv */
// Types for the monitor alert select logic.
// Assumes the consts header is compiled alongside.
`default_nettype none
package masl_pkg;
    typedef enum logic [4:0] {
        MASL_SEL_NONE  = 5'h00,
        MASL_SEL_POWO  = 5'h01,
        MASL_SEL_BUSU  = 5'h02,
        MASL_SEL_BUSO  = 5'h04,
        MASL_SEL_SHNTU = 5'h08,
        MASL_SEL_SHNTO = 5'h10
    } masl_sel_t;
endpackage : masl_pkg
`default_nettype wire

/* File: shared/masl_cmp_if.sv */
// Carrier between the control block and the limit comparator.
// Assumes both ends share clk.
`timescale 1ns/1ps
`default_nettype none
interface masl_cmp_if;
    logic [4:0]  funcEn;     // Enabled limit functions, bit 4 highest
    logic [15:0] limit;      // Shared limit value
    logic [15:0] shuntVal;   // Shunt result
    logic [15:0] busVal;     // Bus result
    logic [15:0] powerVal;   // Power result
    logic        shuntDone;  // Shunt conversion complete
    logic        busDone;    // Bus conversion complete
    logic        evalStb;    // A check was evaluated this cycle
    logic        hit;        // Evaluated check found an alert condition
    modport ctrl (output funcEn, limit, shuntVal, busVal, powerVal,
                  shuntDone, busDone, input evalStb, hit);
    modport cmp  (input funcEn, limit, shuntVal, busVal, powerVal,
                  shuntDone, busDone, output evalStb, hit);
endinterface : masl_cmp_if
`default_nettype wire

/* File: rtl/masl_limit_cmp.sv */
// Priority select and limit comparison for the alert logic.
// Assumes results and done strobes are on clk.
`include "masl_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module masl_limit_cmp
    import masl_pkg::*;
(
    masl_cmp_if.cmp cmpIf  // Comparator side
);
    masl_sel_t sel;
    wire [4:0] en = cmpIf.funcEn;
    // Highest enabled function wins
    assign sel = en[4] ? MASL_SEL_SHNTO :
                 en[3] ? MASL_SEL_SHNTU :
                 en[2] ? MASL_SEL_BUSO  :
                 en[1] ? MASL_SEL_BUSU  :
                 en[0] ? MASL_SEL_POWO  : MASL_SEL_NONE;
    wire signed [15:0] lim = cmpIf.limit;
    wire shOver  = $signed(cmpIf.shuntVal) > lim;
    wire shUnder = $signed(cmpIf.shuntVal) < lim;
    wire bsOver  = cmpIf.busVal > cmpIf.limit;
    wire bsUnder = cmpIf.busVal < cmpIf.limit;
    wire pwOver  = cmpIf.powerVal > cmpIf.limit;
    logic hitC;
    logic evC;
    always_comb begin
        case (sel)
            MASL_SEL_SHNTO: begin
                hitC = shOver;
                evC  = cmpIf.shuntDone;
            end
            MASL_SEL_SHNTU: begin
                hitC = shUnder;
                evC  = cmpIf.shuntDone;
            end
            MASL_SEL_BUSO: begin
                hitC = bsOver;
                evC  = cmpIf.busDone;
            end
            MASL_SEL_BUSU: begin
                hitC = bsUnder;
                evC  = cmpIf.busDone;
            end
            MASL_SEL_POWO: begin
                hitC = pwOver;
                evC  = cmpIf.busDone;
            end
            default: begin
                hitC = 1'h0;
                evC  = cmpIf.shuntDone | cmpIf.busDone;
            end
        endcase
    end
    assign cmpIf.hit     = hitC;
    assign cmpIf.evalStb = evC;
endmodule : masl_limit_cmp
`default_nettype wire

/* File: rtl/masl_alert_ctrl.sv */
// Alert control register, flags and open-collector alert pin.
// Assumes measurement core strobes on clk and a register port that
// supplies the 8-bit register index; the decode for index 06h is done here.
// Holds the control word, the three status flags and the pin drive;
// the priority select and the compares sit in the limit comparator.
`include "masl_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module masl_alert_ctrl
    import masl_pkg::*;
(
    input  wire logic        clk,         // 50 MHz clock
    input  wire logic        rst_b,       // Async reset, active low
    input  wire logic [7:0]  regIndex,    // Register index of access
    input  wire logic        regWr,       // Write strobe, one cycle
    input  wire logic        regRd,       // Read strobe, one cycle
    input  wire logic [15:0] regWdata,    // Write data
    output logic      [15:0] regRdata,    // Control register readback
    input  wire logic        cfgWr,       // Config write, not power-down
    input  wire logic [15:0] limitVal,    // Shared limit register
    input  wire logic [15:0] shuntVal,    // Shunt result
    input  wire logic [15:0] busVal,      // Bus result
    input  wire logic [15:0] powerVal,    // Power result
    input  wire logic        shuntDone,   // Shunt conversion done pulse
    input  wire logic        busDone,     // Bus conversion done pulse
    input  wire logic        allDone,     // All conversions/math done
    input  wire logic        mathOvf,     // Arithmetic overflow pulse
    output logic             alertOut,    // Alert pin drive level
    output logic             alertOe_b    // Alert pin enable, low drives
);
    // ==================================================================
    // Comparator hookup
    // ==================================================================
    masl_cmp_if cmpIf ();

    masl_limit_cmp masl_limit_cmp_i (
        .cmpIf (cmpIf.cmp)
    );

    // ==================================================================
    // State and next-state values
    // ==================================================================
    logic [15:0] ctrl_q;
    logic [15:0] ctrl_d;
    logic        limFlag_q;
    logic        limFlag_d;
    logic        doneFlag_q;
    logic        doneFlag_d;
    logic        mathFlag_q;
    logic        mathFlag_d;

    // ==================================================================
    // Register decode
    // ==================================================================
    // Other indexes belong to other registers and are ignored here
    wire        selCtrl = (regIndex == `MASL_CTRL_INDEX);
    wire        ctrlWr  = regWr & selCtrl;
    wire        ctrlRd  = regRd & selCtrl;
    wire [15:0] wrMask  = `MASL_WR_MASK;

    // ==================================================================
    // Control register next value
    // ==================================================================
    // Flag positions stay zero here; readback fills them from the flags
    generate
        for (genvar b = 0; b < `MASL_REG_W; b++) begin : g_ctrl_bit
            assign ctrl_d[b] = (ctrlWr & wrMask[b]) ? regWdata[b] :
                               wrMask[b] ? ctrl_q[b] : 1'h0;
        end
    endgenerate

    // ==================================================================
    // Field decode
    // ==================================================================
    wire shuntOverLimitEnable  = ctrl_q[`MASL_BIT_SH_OVER];
    wire shuntUnderLimitEnable = ctrl_q[`MASL_BIT_SH_UNDER];
    wire busOverLimitEnable    = ctrl_q[`MASL_BIT_BUS_OVER];
    wire busUnderLimitEnable   = ctrl_q[`MASL_BIT_BUS_UNDER];
    wire powerOverLimitEnable  = ctrl_q[`MASL_BIT_PWR_OVER];
    wire readyAlertEnable      = ctrl_q[`MASL_BIT_RDY];
    wire alertLatchSelect      = ctrl_q[`MASL_BIT_LATCH];
    // Sense takes effect with the write that sets it
    wire alertSenseInvert      = ctrl_d[`MASL_BIT_INV];

    // ==================================================================
    // Function select
    // ==================================================================
    // Bit 4 is the highest priority function
    wire [4:0] funcEn  = {shuntOverLimitEnable, shuntUnderLimitEnable,
                          busOverLimitEnable, busUnderLimitEnable,
                          powerOverLimitEnable};
    wire       limitOn = (funcEn != `MASL_FUNC_NONE);

    // ==================================================================
    // Comparator feed
    // ==================================================================
    // Results and strobes pass straight through to the pure compare
    assign cmpIf.funcEn    = funcEn;
    assign cmpIf.limit     = limitVal;
    assign cmpIf.shuntVal  = shuntVal;
    assign cmpIf.busVal    = busVal;
    assign cmpIf.powerVal  = powerVal;
    assign cmpIf.shuntDone = shuntDone;
    assign cmpIf.busDone   = busDone;
    wire evalStb = cmpIf.evalStb;
    wire evalHit = cmpIf.hit;

    // ==================================================================
    // Limit alert flag
    // ==================================================================
    // Only a selected function can raise the flag
    wire limSet  = limitOn & evalStb & evalHit;
    wire limClrT = ~alertLatchSelect & evalStb & ~evalHit;
    wire limClrL = alertLatchSelect & ctrlRd;
    wire limClr  = limClrT | limClrL;
    // Set wins over any clear in the same cycle
    assign limFlag_d = limSet ? 1'h1 :
                       limClr ? 1'h0 : limFlag_q;

    // ==================================================================
    // Conversion done flag
    // ==================================================================
    // Set when the whole conversion and its math are finished
    wire doneSet = allDone;
    wire doneClr = cfgWr | ctrlRd;
    assign doneFlag_d = doneSet ? 1'h1 :
                        doneClr ? 1'h0 : doneFlag_q;

    // ==================================================================
    // Math overflow flag
    // ==================================================================
    // A control read clears it along with the done flag
    wire mathSet = mathOvf;
    wire mathClr = ctrlRd;
    assign mathFlag_d = mathSet ? 1'h1 :
                        mathClr ? 1'h0 : mathFlag_q;

    // ==================================================================
    // Alert pin
    // ==================================================================
    // Ready signalling adds to the limit alert, never replaces it
    wire limitAct = limFlag_d;
    wire readyAct = readyAlertEnable & doneFlag_d;
    wire alertAct = limitAct | readyAct;
    wire idleHigh = ~alertSenseInvert;
    // Open collector: pulled low when the pin level is low, else released
    wire pinLevel = alertAct ^ idleHigh;
    wire oeB_d    = pinLevel;

    // ==================================================================
    // Readback
    // ==================================================================
    // Shows the state as it stands after the access that reads it
    wire [15:0] rdVal_d = {ctrl_d[`MASL_BIT_SH_OVER:`MASL_BIT_LIM_FLAG + 1],
                           limFlag_d,
                           doneFlag_d,
                           mathFlag_d,
                           ctrl_d[`MASL_BIT_INV:`MASL_BIT_LATCH]};

    // ==================================================================
    // Control register
    // ==================================================================
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= `MASL_CTRL_RESET;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // ==================================================================
    // Flag registers
    // ==================================================================
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            limFlag_q <= `MASL_FLAG_RESET;
        end else begin
            limFlag_q <= limFlag_d;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            doneFlag_q <= `MASL_FLAG_RESET;
        end else begin
            doneFlag_q <= doneFlag_d;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mathFlag_q <= `MASL_FLAG_RESET;
        end else begin
            mathFlag_q <= mathFlag_d;
        end
    end

    // ==================================================================
    // Output registers
    // ==================================================================
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            regRdata <= `MASL_CTRL_RESET;
        end else begin
            regRdata <= rdVal_d;
        end
    end

    // The pin level stays low; only its enable moves
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            alertOut <= `MASL_PIN_LOW;
        end else begin
            alertOut <= `MASL_PIN_LOW;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            alertOe_b <= `MASL_OE_RELEASE;
        end else begin
            alertOe_b <= oeB_d;
        end
    end
endmodule : masl_alert_ctrl
`default_nettype wire

/* File: dv/masl_host_model.sv */
// Host side of the alert pin: resolves the open-collector line.
// Assumes a board pull-up holds the released line high.
`timescale 1ns/1ps
`default_nettype none
module masl_host_model (
    input  wire logic alertOut,   // Level driven by the device
    input  wire logic alertOe_b,  // Device drive enable, low drives
    output logic      alertPin    // Resolved pin level
);
    assign alertPin = alertOe_b ? 1'h1 : alertOut;
endmodule : masl_host_model
`default_nettype wire

/* File: dv/masl_alert_chk.sv */
// Checker on the alert control ports.
// Assumes binding to masl_alert_ctrl.
`timescale 1ns/1ps
`default_nettype none
module masl_alert_chk
    import masl_pkg::*;
(
    input wire logic        clk,        // Clock
    input wire logic        rst_b,      // Reset, active low
    input wire logic [7:0]  regIndex,   // Access index
    input wire logic        regWr,      // Write strobe
    input wire logic        regRd,      // Read strobe
    input wire logic [15:0] regWdata,   // Write data
    input wire logic [15:0] regRdata,   // Readback
    input wire logic        cfgWr,      // Config write
    input wire logic [15:0] limitVal,   // Limit
    input wire logic [15:0] shuntVal,   // Shunt result
    input wire logic        shuntDone,  // Shunt done
    input wire logic        allDone,    // All done
    input wire logic        alertOut,   // Pin level
    input wire logic        alertOe_b   // Pin enable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire logic ctlWr = regWr && regIndex == 8'h06;
    wire logic ctlRd = regRd && regIndex == 8'h06;
    AST_WR_KEEP: assert property (ctlWr |=>
        regRdata[15:10] == $past(regWdata[15:10])
        && regRdata[1:0] == $past(regWdata[1:0])) else $error("store bad");
    AST_OTHER_IDX: assert property (
        !ctlWr |=> $stable(regRdata[15:10])) else $error("ctrl changed");
    AST_DONE_SET: assert property (
        allDone |=> regRdata[3]) else $error("done not set");
    AST_DONE_CLR: assert property (
        (cfgWr || ctlRd) && !allDone |=> !regRdata[3]) else $error("done kept");
    AST_LATCH_HOLD: assert property (
        regRdata[4] && regRdata[0] && !ctlRd && !ctlWr |=> regRdata[4])
        else $error("latched flag lost");
    AST_OVER_HIT: assert property (regRdata[15:11] == MASL_SEL_SHNTO
        && shuntDone && !ctlWr && $signed(shuntVal) > $signed(limitVal)
        |=> regRdata[4]) else $error("over-limit missed");
    AST_NO_FUNC: assert property (regRdata[15:11] == 5'h00
        && !regRdata[4] && !ctlWr |=> !regRdata[4]) else $error("stray flag");
    AST_PIN_ACT: assert property (
        regRdata[4] |-> alertOe_b == regRdata[1]) else $error("pin sense");
    AST_OC_LOW: assert property (
        alertOut == 1'h0) else $error("pin driven high");
endmodule : masl_alert_chk
bind masl_alert_ctrl masl_alert_chk masl_alert_chk_i (.clk(clk),
    .rst_b(rst_b), .regIndex(regIndex), .regWr(regWr), .regRd(regRd),
    .regWdata(regWdata), .regRdata(regRdata), .cfgWr(cfgWr),
    .limitVal(limitVal), .shuntVal(shuntVal), .shuntDone(shuntDone),
    .allDone(allDone), .alertOut(alertOut), .alertOe_b(alertOe_b));
`default_nettype wire

/* File: dv/monitor_alert_select_logic_bench.sv */
// Testbench for the alert control block: readback and pin level.
// Assumes the host model and bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module monitor_alert_select_logic_bench;
    localparam logic [5:0] WR = 6'h20, RD = 6'h10, CF = 6'h08, SH = 6'h04;
    localparam logic [5:0] BS = 6'h02, AD = 6'h01;
    logic        clk = 1'h0, rst_b = 1'h0, aOut, oeB, pin;
    logic [7:0]  idx = 8'h06;
    logic [15:0] wd = 16'h0000, lim = 16'h0000, sh = 16'h0000, rdat;
    logic [15:0] bs = 16'h0000, pw = 16'h0000;
    logic [5:0]  stb = 6'h00;
    logic        ovf = 1'h0;
    int          num_errors = 0, n_tests = 0;
    always #10 clk = ~clk;
    masl_alert_ctrl masl_alert_ctrl_i (.clk(clk), .rst_b(rst_b),
        .regIndex(idx), .regWr(stb[5]), .regRd(stb[4]), .regWdata(wd),
        .regRdata(rdat), .cfgWr(stb[3]), .limitVal(lim), .shuntVal(sh),
        .busVal(bs), .powerVal(pw), .shuntDone(stb[2]), .busDone(stb[1]),
        .allDone(stb[0]), .mathOvf(ovf), .alertOut(aOut), .alertOe_b(oeB));
    masl_host_model masl_host_model_i (.alertOut(aOut), .alertOe_b(oeB),
        .alertPin(pin));
    task automatic val(input logic [15:0] l, s, b, p);
        @(posedge clk);
        {lim, sh, bs, pw} <= {l, s, b, p};
    endtask : val
    // One strobe cycle, then compare readback and resolved pin
    task automatic oc(input logic [5:0] s, input logic [15:0] d, e,
                      input logic p, input logic [7:0] i = 8'h06);
        @(posedge clk);
        {stb, wd, idx} <= {s, d, i};
        @(posedge clk);
        stb <= 6'h00;
        #1;
        n_tests++;
        if ({rdat, pin} !== {e, p}) begin
            num_errors++;
            $display("wrong value at %0t: got %h exp %h", $time,
                     {rdat, pin}, {e, p});
        end
    endtask : oc
    task automatic t_reg;
        oc(6'h00, 16'h0000, 16'h0000, 1'h1);
        oc(WR, 16'hFFFF, 16'hFC03, 1'h0);
        oc(WR, 16'h0000, 16'hFC03, 1'h0, 8'h05);
        oc(WR, 16'h0000, 16'h0000, 1'h1);
        $display("register test done");
    endtask : t_reg
    task automatic t_latch;
        val(16'h0064, 16'h00C8, 16'h0000, 16'h0000);
        oc(WR, 16'h8001, 16'h8001, 1'h1);
        oc(SH, 16'h0000, 16'h8011, 1'h0);
        val(16'h0064, 16'h0032, 16'h0000, 16'h0000);
        oc(SH, 16'h0000, 16'h8011, 1'h0);
        oc(RD, 16'h0000, 16'h8001, 1'h1);
        val(16'h0064, 16'h00C8, 16'h0000, 16'h0000);
        oc(WR, 16'h8003, 16'h8003, 1'h0);
        oc(SH, 16'h0000, 16'h8013, 1'h1);
        oc(RD, 16'h0000, 16'h8003, 1'h0);
        $display("latch test done");
    endtask : t_latch
    task automatic t_trans;
        val(16'h0000, 16'hFFF0, 16'h0000, 16'h0000);
        oc(WR, 16'h4000, 16'h4000, 1'h1);
        oc(SH, 16'h0000, 16'h4010, 1'h0);
        val(16'h0000, 16'h0010, 16'h0000, 16'h0000);
        oc(SH, 16'h0000, 16'h4000, 1'h1);
        $display("transparent test done");
    endtask : t_trans
    task automatic t_prio;
        val(16'h0064, 16'h0032, 16'h00C8, 16'h012C);
        oc(WR, 16'hA001, 16'hA001, 1'h1);
        oc(SH | BS, 16'h0000, 16'hA001, 1'h1);
        oc(WR, 16'h2001, 16'h2001, 1'h1);
        oc(BS, 16'h0000, 16'h2011, 1'h0);
        oc(WR, 16'h0801, 16'h0811, 1'h0);
        oc(RD, 16'h0000, 16'h0801, 1'h1);
        oc(BS, 16'h0000, 16'h0811, 1'h0);
        oc(RD, 16'h0000, 16'h0801, 1'h1);
        val(16'h0064, 16'h0032, 16'h0032, 16'h012C);
        oc(WR, 16'h1000, 16'h1000, 1'h1);
        oc(BS, 16'h0000, 16'h1010, 1'h0);
        val(16'h0064, 16'h0032, 16'h00C8, 16'h012C);
        oc(BS, 16'h0000, 16'h1000, 1'h1);
        $display("priority test done");
    endtask : t_prio
    task automatic t_rdy;
        oc(WR, 16'h8400, 16'h8400, 1'h1);
        oc(AD, 16'h0000, 16'h8408, 1'h0);
        oc(CF, 16'h0000, 16'h8400, 1'h1);
        oc(AD, 16'h0000, 16'h8408, 1'h0);
        oc(RD, 16'h0000, 16'h8400, 1'h1);
        $display("ready test done");
    endtask : t_rdy
    task automatic t_ovf;
        @(posedge clk);
        ovf <= 1'h1;
        @(posedge clk);
        ovf <= 1'h0;
        oc(6'h00, 16'h0000, 16'h8404, 1'h1);
        oc(RD, 16'h0000, 16'h8400, 1'h1);
        $display("overflow test done");
    endtask : t_ovf
    task automatic t_rst;
        @(posedge clk);
        rst_b <= 1'h0;
        repeat (2) @(posedge clk);
        rst_b <= 1'h1;
        oc(6'h00, 16'h0000, 16'h0000, 1'h1);
        $display("reset test done");
    endtask : t_rst
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'h1;
        t_reg();
        t_latch();
        t_trans();
        t_prio();
        t_rdy();
        t_ovf();
        t_rst();
        conclude();
    end
    initial begin
        #50000;
        num_errors++;
        conclude();
    end
endmodule : monitor_alert_select_logic_bench
`default_nettype wire
